// file: sim/ext_data_mem.sv
// far-side data memory on the bus port
// assumes the core latches the address with addr_strobe and pulses rd_n / wr_n low
module ext_data_mem (
  input wire logic clk,
  input wire logic addr_strobe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] bus_port_o,
  output logic [7:0] bus_port_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] addr = 8'h00;
  logic [7:0] last = 8'h00;
  always @(posedge clk) begin
    if (addr_strobe) addr <= bus_port_o;
    if (!wr_n) mem[addr] <= bus_port_o;
    if (!rd_n) last <= mem[addr];
  end
  // released bus shows the inverse, so stale data cannot pass for a read
  assign bus_port_i = rd_n ? ~last : mem[addr];
endmodule : ext_data_mem

// file: sim/mcu_timer_interrupt_stack_core_bench.sv
// self-checking bench for the system control core
// assumes mcu_core_pkg and ext_data_mem are compiled first
module mcu_timer_interrupt_stack_core_bench import mcu_core_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {op_code_t c; logic [11:0] t; logic [7:0] a; logic [31:0] e;} row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  op_req_t op = '0;
  op_result_t result;
  logic [11:0] prog_addr;
  logic internal_fetch, int_taken, bus_port_oe, addr_strobe, rd_n, wr_n, ale;
  logic int_n = 1'b1;
  logic cnt_pin = 1'b1;
  logic [7:0] port2_i = 8'h96;
  logic [7:0] port1_o, port1_oe, port2_o, port2_oe, bus_port_o, bus_port_i;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rr;
  logic [11:0] pcat;
  logic [7:0] rd;
  logic jt;
  int miscompares = 0;
  int checked = 0;
  int lows, seen, oes;
  row_t rows [12] = '{
    '{OP_PICK_REGISTER_BANK_ONE, 12'h000, REG_STATUS, 32'h020},
    '{OP_PICK_CODE_BANK_ONE, 12'h000, REG_STATUS, 32'h060},
    '{OP_JUMP, 12'h123, REG_PC, 32'h923},
    '{OP_PICK_CODE_BANK_ZERO, 12'h000, REG_STATUS, 32'h020},
    '{OP_CALL, 12'h045, REG_PC, 32'h045},
    '{OP_CALL, 12'h100, REG_STATUS, 32'h022},
    '{OP_SUBROUTINE_EXIT, 12'h000, REG_STATUS, 32'h021},
    '{OP_FETCH, 12'h000, REG_PC, 32'h046},
    '{OP_TMR_INT_ENABLE, 12'h000, REG_INT_EN, 32'h2},
    '{OP_EXT_INT_ENABLE, 12'h000, REG_INT_EN, 32'h3},
    '{OP_EXT_INT_DISABLE, 12'h000, REG_INT_EN, 32'h2},
    '{OP_TMR_INT_DISABLE, 12'h000, REG_INT_EN, 32'h0}};

  mcu_core uut (.clk(clk), .rst(rst), .op(op), .result(result), .prog_addr(prog_addr),
    .internal_fetch(internal_fetch), .ext_access(1'b0), .int_n(int_n),
    .count_input_pin(cnt_pin), .ale(ale), .int_taken(int_taken), .port1_i(8'h00),
    .port1_o(port1_o), .port1_oe(port1_oe), .port2_i(port2_i), .port2_o(port2_o),
    .port2_oe(port2_oe), .bus_port_i(bus_port_i), .bus_port_o(bus_port_o),
    .bus_port_oe(bus_port_oe), .addr_strobe(addr_strobe), .rd_n(rd_n), .wr_n(wr_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  ext_data_mem mem_model (.clk(clk), .addr_strobe(addr_strobe), .rd_n(rd_n), .wr_n(wr_n),
    .bus_port_o(bus_port_o), .bus_port_i(bus_port_i));

  initial forever #5 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task results;
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task rget(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rr = reg_rdata;
  endtask : rget
  task rset(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : rset
  // issue one op, then watch n cycles for result and strobe lows
  task do_op(input op_code_t c, input logic [2:0] s, input logic [7:0] d, input int n);
    @(posedge clk);
    op <= '{1'b1, c, s, d, 12'h000};
    @(posedge clk);
    op <= '0;
    rd = 'x;
    jt = 1'b0;
    lows = 0;
    oes = 0;
    repeat (n) begin
      #1 if (result.valid === 1'b1) rd = result.data;
      if (result.jump_taken === 1'b1) jt = 1'b1;
      if (rd_n === 1'b0 || wr_n === 1'b0) lows++;
      if (bus_port_oe === 1'b1) oes++;
      @(posedge clk);
    end
  endtask : do_op
  task wint(input int n);
    seen = 0;
    repeat (n) begin
      #1 if (int_taken === 1'b1) begin
        seen++;
        pcat = prog_addr;
      end
      @(posedge clk);
    end
  endtask : wint

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("pc", PC_RESET, prog_addr);
    chk("port1_o", 8'hff, port1_o);
    chk("port2_oe", 8'h00, port2_oe);
    chk("strobes", 3'b011, {bus_port_oe, rd_n, wr_n});
    rget(REG_STATUS);
    chk("status", 32'h0, rr);
    chk("fetch", 1'b1, internal_fetch);
    foreach (rows[i]) begin
      @(posedge clk);
      op <= '{1'b1, rows[i].c, 3'h0, 8'h00, rows[i].t};
      @(posedge clk);
      op <= '0;
      rget(rows[i].a);
      chk("row", rows[i].e, rr);
    end
    @(posedge clk);
    op <= '{1'b1, OP_CALL, 3'h0, 8'h00, 12'h200};
    @(posedge clk);
    op <= '{1'b1, OP_SUBROUTINE_EXIT, 3'h0, 8'h00, 12'h000};
    @(posedge clk);
    op <= '0;
    rget(REG_PC);
    chk("call_ret", 32'h046, rr);
    do_op(OP_REG_WRITE, 3'h0, 8'h09, 1);
    do_op(OP_IND_READ, 3'h0, 8'h00, 1);
    chk("stack_hi", 8'h19, rd);
    do_op(OP_PICK_REGISTER_BANK_ZERO, 3'h0, 8'h00, 1);
    do_op(OP_REG_WRITE, 3'h0, 8'h18, 1);
    do_op(OP_IND_READ, 3'h0, 8'h00, 1);
    chk("bank1_r0", 8'h09, rd);
    do_op(OP_PORT_WRITE, 3'h0, 8'h3c, 1);
    chk("port1_oe", {8'h3c, 8'hc3}, {port1_o, port1_oe});
    do_op(OP_PORT_READ, 3'h1, 8'h00, 1);
    chk("port2_in", 8'h96, rd);
    do_op(OP_REG_WRITE, 3'h1, 8'h40, 1);
    do_op(OP_REG_READ, 3'h1, 8'h00, 1);
    chk("reg_read", 8'h40, rd);
    do_op(OP_IND_WRITE, 3'h1, 8'h77, 1);
    do_op(OP_IND_READ, 3'h1, 8'h00, 1);
    chk("ind_rw", 8'h77, rd);
    do_op(OP_EXTERNAL_TRANSFER_WRITE, 3'h1, 8'ha5, 7);
    chk("wr_low", 3, lows);
    chk("wr_oe", 4, oes);
    chk("xmem", 8'ha5, mem_model.mem[8'h40]);
    do_op(OP_EXTERNAL_TRANSFER_READ, 3'h1, 8'h00, 7);
    chk("xread", {8'ha5, 8'h03}, {rd, 8'(lows)});
    chk("bus_oe", 1'b0, bus_port_oe);
    do_op(OP_BUS_STATIC_WRITE, 3'h0, 8'h5a, 7);
    chk("static_wr", {8'h5a, 8'h03, 8'h03}, {mem_model.mem[8'h40], 8'(lows), 8'(oes)});
    do_op(OP_BUS_STATIC_READ, 3'h0, 8'h00, 7);
    chk("static_rd", {8'h5a, 8'h03}, {rd, 8'(lows)});
    rset(REG_INT_EN, 32'h3);
    rget(REG_INT_EN);
    chk("int_en", 32'h3, rr);
    rget(8'h10);
    chk("unmapped", 32'h0, rr);
    do_op(OP_LOAD_COUNTER, 3'h0, 8'hfe, 1);
    rget(REG_COUNTER);
    chk("counter", 32'hfe, rr);
    do_op(OP_READ_COUNTER, 3'h0, 8'h00, 1);
    chk("counter_op", 8'hfe, rd);
    do_op(OP_START_TIMER, 3'h0, 8'h00, 1);
    wint(1200);
    chk("tmr_vec", {VEC_TMR_INT, 4'h1}, {pcat, 4'(seen)});
    int_n <= 1'b0;
    wint(100);
    chk("nested", 0, seen);
    do_op(OP_HALT_COUNTER, 3'h0, 8'h00, 1);
    rget(REG_STATUS);
    chk("run_ovf", 2'b01, {rr[8], rr[7]});
    do_op(OP_TEST_OVERFLOW_FLAG_JUMP, 3'h0, 8'h00, 1);
    chk("ovf_jump", 1'b1, jt);
    do_op(OP_TEST_OVERFLOW_FLAG_JUMP, 3'h0, 8'h00, 1);
    chk("ovf_clear", 1'b0, jt);
    do_op(OP_SERVICE_EXIT_REARM, 3'h0, 8'h00, 1);
    wint(60);
    chk("ext_vec", {VEC_EXT_INT, 4'h1}, {pcat, 4'(seen)});
    int_n <= 1'b1;
    // reset in mid-run: counter must survive it, core state must not
    do_op(OP_LOAD_COUNTER, 3'h0, 8'hfe, 1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    seen = 0;
    repeat (30) begin
      @(posedge clk);
      #1 if (ale === 1'b1) seen++;
    end
    chk("ale_count", 2, seen);
    chk("rst_pc_port", {12'h000, 8'hff}, {prog_addr, port1_o});
    rget(REG_STATUS);
    chk("rst_status", 32'h0, rr);
    rget(REG_COUNTER);
    chk("rst_counter", 32'hfe, rr);
    do_op(OP_START_EVENT_COUNT, 3'h0, 8'h00, 1);
    // period of 60 clocks keeps above three machine cycles
    repeat (2) begin
      cnt_pin <= 1'b0;
      repeat (30) @(posedge clk);
      cnt_pin <= 1'b1;
      repeat (30) @(posedge clk);
    end
    rget(REG_COUNTER);
    chk("evt_count", 32'h00, rr);
    rget(REG_STATUS);
    chk("evt_status", 32'h780, rr);
    int_n <= 1'b0;
    rset(REG_INT_EN, 32'h3);
    wint(40);
    chk("prio_ext", {VEC_EXT_INT, 4'h1}, {pcat, 4'(seen)});
    int_n <= 1'b1;
    repeat (20) @(posedge clk);
    do_op(OP_SERVICE_EXIT_REARM, 3'h0, 8'h00, 1);
    wint(40);
    chk("prio_tmr", {VEC_TMR_INT, 4'h1}, {pcat, 4'(seen)});
    results();
  end

  initial begin
    #(20000 * 10);
    miscompares++;
    results();
  end
endmodule : mcu_timer_interrupt_stack_core_bench

// file: verilog/mcu_core.sv
// system control core: program counter, banks, stack, ports, bus port, timer, interrupts
// assumes the decoder issues ops on clk; pins arrive asynchronous and are synchronised
//
// The address-and-strobe port and the address map were left to the implementer.
module mcu_core import mcu_core_pkg::*; #(
  parameter int RAM_WORDS = RAM_WORDS_LARGE,
  parameter int ROM_BYTES = ROM_BYTES_SMALL
) (
  input wire logic clk,
  input wire logic rst,
  input wire op_req_t op,
  output op_result_t result,
  output logic [11:0] prog_addr,
  output logic internal_fetch,
  input wire logic ext_access,
  input wire logic int_n,
  input wire logic count_input_pin,
  output logic ale,
  output logic int_taken,
  input wire logic [7:0] port1_i,
  output logic [7:0] port1_o,
  output logic [7:0] port1_oe,
  input wire logic [7:0] port2_i,
  output logic [7:0] port2_o,
  output logic [7:0] port2_oe,
  input wire logic [7:0] bus_port_i,
  output logic [7:0] bus_port_o,
  output logic bus_port_oe,
  output logic addr_strobe,
  output logic rd_n,
  output logic wr_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  localparam int AW = $clog2(RAM_WORDS);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] pc;
    logic bank_pending;
    logic reg_bank;
    logic [2:0] sp;
    logic [7:0] p1;
    logic [7:0] p2;
    logic tmr_run;
    logic evt_mode;
    logic ovf_flag;
    logic tmr_req;
    logic [4:0] prescale;
    logic [3:0] mcycle;
    logic ie_ext;
    logic ie_tmr;
    logic in_service;
    logic ext_pend;
    logic tmr_pend;
    bus_phase_t bus_ph;
    logic [1:0] strobe_cnt;
    logic bus_read;
    logic bus_ext;
    logic [7:0] bus_data;
    logic [7:0] db_o;
    logic db_oe;
    logic addr_stb;
    logic rd_n;
    logic wr_n;
    logic ale;
    logic int_taken;
    logic internal_fetch;
    op_result_t res;
    logic [31:0] rdata;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic t1_prev;
    logic [23:0] pin_sync1;
    logic [23:0] pin_sync2;
  } core_state_t;

  // memory and counter keep their content over reset
  typedef struct packed {
    logic [RAM_WORDS-1:0][7:0] ram;
    logic [7:0] counter;
  } keep_state_t;

  localparam core_state_t CORE_RESET = '{
    pc: PC_RESET, bus_ph: BUS_IDLE, rd_n: 1'b1, wr_n: 1'b1,
    p1: 8'hff, p2: 8'hff, sync1: 3'h7, sync2: 3'h7, t1_prev: 1'b1,
    res: '0, default: '0
  };

  core_state_t s, next_s;
  keep_state_t m, next_m;

  logic int_pin_low;
  logic t1_now;
  logic ea_now;
  logic [AW-1:0] wbase;
  logic [AW-1:0] wreg_idx;
  logic [AW-1:0] ptr_idx;
  logic [7:0] ptr_val;
  logic ptr_internal;
  logic [AW-1:0] stk_lo;
  logic [AW-1:0] pop_lo;
  logic [2:0] pop_sp;
  logic tick;
  logic can_take;
  logic op_go;

  assign int_pin_low = ~s.sync2[0];
  assign t1_now = s.sync2[1];
  assign ea_now = s.sync2[2];
  assign wbase = s.reg_bank ? AW'(WREG_BANK1_BASE) : AW'(WREG_BANK0_BASE);
  assign wreg_idx = wbase + AW'(op.sel);
  assign ptr_val = m.ram[wbase + AW'(op.sel[0])];
  assign ptr_internal = ({24'h0, ptr_val} < 32'(RAM_WORDS));
  assign ptr_idx = ptr_val[AW-1:0];
  assign stk_lo = AW'(STACK_BASE) + AW'({s.sp, 1'b0});
  assign pop_sp = s.sp - 3'h1;
  assign pop_lo = AW'(STACK_BASE) + AW'({pop_sp, 1'b0});
  assign op_go = op.valid && op.code != OP_NOP;
  // an interrupt is only taken between ops and with the bus at rest
  assign can_take = !s.in_service && !op_go && s.bus_ph == BUS_IDLE
    && (s.ext_pend || s.tmr_pend);

  always_comb begin
    next_s = s;
    next_m = m;
    tick = 1'b0;
    next_s.res = '0;
    next_s.int_taken = 1'b0;
    next_s.addr_stb = 1'b0;
    // ----------------------------------------------------------------
    // synchronisers: first stage feeds only the second
    // ----------------------------------------------------------------
    next_s.sync1 = {ext_access, count_input_pin, int_n};
    next_s.sync2 = s.sync1;
    next_s.pin_sync1 = {bus_port_i, port2_i, port1_i};
    next_s.pin_sync2 = s.pin_sync1;
    next_s.t1_prev = t1_now;

    // ----------------------------------------------------------------
    // machine cycle, interrupt sampling
    // ----------------------------------------------------------------
    next_s.mcycle = (s.mcycle == MCYCLE_LAST) ? 4'h0 : s.mcycle + 4'h1;
    next_s.ale = (next_s.mcycle == 4'h0);
    if (s.ale) begin
      next_s.ext_pend = int_pin_low && s.ie_ext;
      next_s.tmr_pend = s.tmr_req && s.ie_tmr;
      next_s.prescale = (s.prescale == PRESCALE_LAST) ? 5'h0 : s.prescale + 5'h1;
    end

    // ----------------------------------------------------------------
    // timer / event counter
    // ----------------------------------------------------------------
    if (s.tmr_run) begin
      if (s.evt_mode)
        tick = s.t1_prev && !t1_now;
      else
        tick = s.ale && s.prescale == PRESCALE_LAST;
    end
    if (tick) begin
      next_m.counter = m.counter + 8'h01;
      if (m.counter == 8'hff) begin
        next_s.ovf_flag = 1'b1;
        next_s.tmr_req = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // bus port sequencer
    // ----------------------------------------------------------------
    unique case (s.bus_ph)
      BUS_IDLE: begin
        next_s.db_oe = 1'b0;
      end
      BUS_ADDR: begin
        next_s.bus_ph = BUS_STROBE;
        next_s.strobe_cnt = 2'h0;
        next_s.db_o = s.bus_data;
        next_s.db_oe = !s.bus_read;
        next_s.rd_n = !s.bus_read;
        next_s.wr_n = s.bus_read;
      end
      BUS_STROBE: begin
        next_s.strobe_cnt = s.strobe_cnt + 2'h1;
        if (s.strobe_cnt == STROBE_LAST) begin
          next_s.bus_ph = BUS_IDLE;
          next_s.rd_n = 1'b1;
          next_s.wr_n = 1'b1;
          next_s.db_oe = 1'b0;
          if (s.bus_read) begin
            next_s.res.valid = 1'b1;
            next_s.res.data = s.pin_sync2[23:16];
          end
        end
      end
      default: begin
        next_s.bus_ph = BUS_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // operations
    // ----------------------------------------------------------------
    if (op.valid) begin
      unique case (op.code)
        OP_NOP: begin
        end
        OP_FETCH: next_s.pc = {s.pc[11], s.pc[10:0] + 11'h001};
        OP_JUMP: next_s.pc = {s.bank_pending, op.target[10:0]};
        OP_CALL: begin
          next_m.ram[stk_lo] = s.pc[7:0];
          next_m.ram[stk_lo + AW'(1)] = {3'h0, s.reg_bank, s.pc[11:8]};
          next_s.sp = s.sp + 3'h1;
          next_s.pc = {s.bank_pending, op.target[10:0]};
        end
        OP_SUBROUTINE_EXIT: begin
          next_s.sp = pop_sp;
          next_s.pc = {m.ram[pop_lo + AW'(1)][3:0], m.ram[pop_lo]};
        end
        OP_SERVICE_EXIT_REARM: begin
          next_s.sp = pop_sp;
          next_s.pc = {m.ram[pop_lo + AW'(1)][3:0], m.ram[pop_lo]};
          next_s.reg_bank = m.ram[pop_lo + AW'(1)][4];
          next_s.in_service = 1'b0;
        end
        OP_PICK_CODE_BANK_ZERO: next_s.bank_pending = 1'b0;
        OP_PICK_CODE_BANK_ONE: next_s.bank_pending = 1'b1;
        OP_PICK_REGISTER_BANK_ZERO: next_s.reg_bank = 1'b0;
        OP_PICK_REGISTER_BANK_ONE: next_s.reg_bank = 1'b1;
        OP_REG_WRITE: next_m.ram[wreg_idx] = op.data;
        OP_REG_READ: next_s.res = '{valid: 1'b1, data: m.ram[wreg_idx], jump_taken: 1'b0};
        OP_IND_WRITE: begin
          if (ptr_internal)
            next_m.ram[ptr_idx] = op.data;
        end
        OP_IND_READ: begin
          next_s.res.valid = 1'b1;
          next_s.res.data = ptr_internal ? m.ram[ptr_idx] : 8'h00;
        end
        OP_PORT_WRITE: begin
          if (op.sel[0])
            next_s.p2 = op.data;
          else
            next_s.p1 = op.data;
        end
        OP_PORT_READ: begin
          next_s.res.valid = 1'b1;
          next_s.res.data = op.sel[0] ? s.pin_sync2[15:8] : s.pin_sync2[7:0];
        end
        OP_BUS_STATIC_WRITE, OP_BUS_STATIC_READ,
        OP_EXTERNAL_TRANSFER_WRITE, OP_EXTERNAL_TRANSFER_READ: begin
          // a new bus op while the strobe is still out is dropped
          if (s.bus_ph == BUS_IDLE) begin
            next_s.bus_read = op.code == OP_BUS_STATIC_READ
              || op.code == OP_EXTERNAL_TRANSFER_READ;
            next_s.bus_ext = op.code == OP_EXTERNAL_TRANSFER_WRITE
              || op.code == OP_EXTERNAL_TRANSFER_READ;
            next_s.bus_data = op.data;
            next_s.bus_ph = BUS_ADDR;
            if (next_s.bus_ext) begin
              next_s.db_o = ptr_val;
              next_s.db_oe = 1'b1;
              next_s.addr_stb = 1'b1;
            end
          end
        end
        OP_START_TIMER: begin
          next_s.tmr_run = 1'b1;
          next_s.evt_mode = 1'b0;
        end
        OP_START_EVENT_COUNT: begin
          next_s.tmr_run = 1'b1;
          next_s.evt_mode = 1'b1;
        end
        OP_HALT_COUNTER: next_s.tmr_run = 1'b0;
        OP_LOAD_COUNTER: next_m.counter = op.data;
        OP_READ_COUNTER: next_s.res = '{valid: 1'b1, data: m.counter, jump_taken: 1'b0};
        OP_TEST_OVERFLOW_FLAG_JUMP: begin
          next_s.res.jump_taken = s.ovf_flag;
          if (s.ovf_flag)
            next_s.pc = {s.pc[11:8], op.target[7:0]};
          // an overflow in this very cycle keeps the flag set
          next_s.ovf_flag = tick && m.counter == 8'hff;
        end
        OP_EXT_INT_ENABLE: next_s.ie_ext = 1'b1;
        OP_EXT_INT_DISABLE: next_s.ie_ext = 1'b0;
        OP_TMR_INT_ENABLE: next_s.ie_tmr = 1'b1;
        OP_TMR_INT_DISABLE: next_s.ie_tmr = 1'b0;
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // interrupt entry
    // ----------------------------------------------------------------
    if (can_take) begin
      next_m.ram[stk_lo] = s.pc[7:0];
      next_m.ram[stk_lo + AW'(1)] = {3'h0, s.reg_bank, s.pc[11:8]};
      next_s.sp = s.sp + 3'h1;
      next_s.in_service = 1'b1;
      next_s.int_taken = 1'b1;
      if (s.ext_pend) begin
        next_s.pc = VEC_EXT_INT;
        next_s.ext_pend = 1'b0;
      end else begin
        next_s.pc = VEC_TMR_INT;
        next_s.tmr_pend = 1'b0;
        next_s.tmr_req = tick && m.counter == 8'hff;
      end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    if (reg_wr) begin
      if (reg_addr == REG_COUNTER)
        next_m.counter = reg_wdata[7:0];
      if (reg_addr == REG_INT_EN) begin
        next_s.ie_ext = reg_wdata[INT_EN_EXT_BIT];
        next_s.ie_tmr = reg_wdata[INT_EN_TMR_BIT];
      end
    end
    next_s.rdata = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: next_s.rdata = {20'h0, s.in_service, s.tmr_req, s.evt_mode, s.tmr_run,
          s.ovf_flag, s.bank_pending, s.reg_bank, s.ie_tmr, s.ie_ext, s.sp};
        REG_PC: next_s.rdata = {20'h0, s.pc};
        REG_COUNTER: next_s.rdata = {24'h0, m.counter};
        REG_INT_EN: next_s.rdata = {30'h0, s.ie_tmr, s.ie_ext};
        default: next_s.rdata = 32'h0;
      endcase
    end

    next_s.internal_fetch = !ea_now && ({20'h0, next_s.pc} < 32'(ROM_BYTES));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= CORE_RESET;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk) begin
    m <= next_m;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign result = s.res;
  assign prog_addr = s.pc;
  assign internal_fetch = s.internal_fetch;
  assign ale = s.ale;
  assign int_taken = s.int_taken;
  assign port1_o = s.p1;
  assign port1_oe = ~s.p1;
  assign port2_o = s.p2;
  assign port2_oe = ~s.p2;
  assign bus_port_o = s.db_o;
  assign bus_port_oe = s.db_oe;
  assign addr_strobe = s.addr_stb;
  assign rd_n = s.rd_n;
  assign wr_n = s.wr_n;
  assign reg_rdata = s.rdata;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ext_vector: assert property (int_taken && $past(s.ext_pend) |-> prog_addr == 12'h003)
    else $error("external interrupt did not vector to 3");
  a_tmr_vector: assert property (int_taken && !$past(s.ext_pend) |-> prog_addr == 12'h007)
    else $error("timer interrupt did not vector to 7");
  a_bank_on_jump: assert property (op.valid && op.code == OP_JUMP |=> prog_addr[11] == $past(s.bank_pending))
    else $error("jump did not load pending bank");
  a_push_inc_sp: assert property (op.valid && op.code == OP_CALL && !can_take |=> s.sp == $past(s.sp) + 3'h1)
    else $error("call did not advance stack pointer");
  a_call_ret_pair: assert property (op.valid && op.code == OP_CALL ##1 op.valid && op.code == OP_SUBROUTINE_EXIT |=> prog_addr == $past(prog_addr, 2) && s.sp == $past(s.sp, 2))
    else $error("return did not restore call site");
  a_bus_float: assert property (s.bus_ph == BUS_IDLE && rd_n && wr_n && !addr_strobe |-> !bus_port_oe)
    else $error("bus driven while idle");
  a_strobe_width: assert property ($fell(wr_n) |-> !wr_n [*3] ##1 wr_n)
    else $error("write strobe length wrong");
  a_single_level: assert property (s.in_service && !(op.valid && op.code == OP_SERVICE_EXIT_REARM) |=> !int_taken)
    else $error("nested interrupt taken");
  a_ovf_sets: assert property (tick && m.counter == 8'hff && !can_take |=> s.ovf_flag && s.tmr_req)
    else $error("wrap did not set overflow");
  a_ovf_clear: assert property (op.valid && op.code == OP_TEST_OVERFLOW_FLAG_JUMP && !tick |=> !s.ovf_flag)
    else $error("overflow jump did not clear flag");
  a_ale_period: assert property ($rose(ale) |=> !ale [*8] ##1 !ale [*6] ##1 ale)
    else $error("machine cycle strobe period wrong");
  a_ext_priority: assert property (can_take && s.ext_pend && s.tmr_pend |=> prog_addr == 12'h003 && s.tmr_pend)
    else $error("timer served before external");

  c_ext_int: cover property (int_taken && prog_addr == 12'h003);
  c_tmr_int: cover property (int_taken && prog_addr == 12'h007);
  c_bus_read: cover property ($rose(rd_n) && result.valid);
  c_ovf_jump: cover property (result.jump_taken);

endmodule : mcu_core

// file: verilog/mcu_core_pkg.sv
// package for the microcontroller system control core: constants, opcodes, carriers
// assumes one 100 MHz clock that stands in for the oscillator
package mcu_core_pkg;

  // ----------------------------------------------------------------
  // program memory and vectors
  // ----------------------------------------------------------------
  localparam int PC_W = 12;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT_INT = 12'h003;
  localparam logic [11:0] VEC_TMR_INT = 12'h007;
  localparam int ROM_BYTES_SMALL = 1024;

  // ----------------------------------------------------------------
  // data memory layout
  // ----------------------------------------------------------------
  localparam int RAM_WORDS_LARGE = 128;
  localparam logic [7:0] WREG_BANK0_BASE = 8'h00;
  localparam logic [7:0] WREG_BANK1_BASE = 8'h18;
  localparam logic [7:0] STACK_BASE = 8'h08;

  // ----------------------------------------------------------------
  // timing: clk is the oscillator, one machine cycle is 15 of it
  // ----------------------------------------------------------------
  localparam int OSC_PER_MCYCLE = 15;
  localparam int TIMER_DIV_OSC = 480;
  localparam int TIMER_PRESCALE = TIMER_DIV_OSC / OSC_PER_MCYCLE;
  localparam logic [3:0] MCYCLE_LAST = 4'(OSC_PER_MCYCLE - 1);
  localparam logic [4:0] PRESCALE_LAST = 5'(TIMER_PRESCALE - 1);
  localparam logic [1:0] STROBE_LAST = 2'h2;

  // ----------------------------------------------------------------
  // register port map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_PC = 8'h04;
  localparam logic [7:0] REG_COUNTER = 8'h08;
  localparam logic [7:0] REG_INT_EN = 8'h0c;
  localparam int INT_EN_EXT_BIT = 0;
  localparam int INT_EN_TMR_BIT = 1;

  // ----------------------------------------------------------------
  // operations handed over by the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_FETCH = 5'h01, OP_JUMP = 5'h02, OP_CALL = 5'h03,
    OP_SUBROUTINE_EXIT = 5'h04, OP_SERVICE_EXIT_REARM = 5'h05,
    OP_PICK_CODE_BANK_ZERO = 5'h06, OP_PICK_CODE_BANK_ONE = 5'h07,
    OP_PICK_REGISTER_BANK_ZERO = 5'h08, OP_PICK_REGISTER_BANK_ONE = 5'h09,
    OP_REG_WRITE = 5'h0a, OP_REG_READ = 5'h0b, OP_IND_WRITE = 5'h0c, OP_IND_READ = 5'h0d,
    OP_PORT_WRITE = 5'h0e, OP_PORT_READ = 5'h0f,
    OP_BUS_STATIC_WRITE = 5'h10, OP_BUS_STATIC_READ = 5'h11,
    OP_EXTERNAL_TRANSFER_WRITE = 5'h12, OP_EXTERNAL_TRANSFER_READ = 5'h13,
    OP_START_TIMER = 5'h14, OP_START_EVENT_COUNT = 5'h15, OP_HALT_COUNTER = 5'h16,
    OP_LOAD_COUNTER = 5'h17, OP_READ_COUNTER = 5'h18, OP_TEST_OVERFLOW_FLAG_JUMP = 5'h19,
    OP_EXT_INT_ENABLE = 5'h1a, OP_EXT_INT_DISABLE = 5'h1b,
    OP_TMR_INT_ENABLE = 5'h1c, OP_TMR_INT_DISABLE = 5'h1d
  } op_code_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00, BUS_ADDR = 2'b01, BUS_STROBE = 2'b10
  } bus_phase_t;

  typedef struct packed {
    logic valid;
    op_code_t code;
    logic [2:0] sel;
    logic [7:0] data;
    logic [11:0] target;
  } op_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic jump_taken;
  } op_result_t;

endpackage : mcu_core_pkg
